// [dcf_ctrl.sv]
`timescale 1ns/100ps
module dcf_ctrl (
	// Clock and reset
	input  wire logic                        core_clk_i,
	input  wire logic                        reset_n_i,
	// Initialization
	input  wire logic                        full_init_n_i,
	input  wire logic                        pointer_only_init_n_i,
	// Straps, sampled during full init
	input  wire logic                        first_word_show_or_serial_in_i,
	input  wire logic                        width_match_en_i,
	input  wire logic                        write_width_sel_i,
	input  wire logic                        read_width_sel_i,
	input  wire logic                        byte_order_sel_n_i,
	input  wire logic                        reread_latency_sel_i,
	input  wire logic                        threshold_flag_timing_sel_i,
	input  wire logic                        parity_position_sel_i,
	input  wire logic                        default_limit_pick0_i,
	input  wire logic                        default_limit_pick1_i,
	input  wire logic                        offset_access_n_i,
	// Write side
	input  wire logic                        write_en_n_i,
	input  wire logic [dcf_pkg::DATA_W-1:0]  write_data_i,
	input  wire logic                        serial_load_n_i,
	// Read side
	input  wire logic                        read_en_n_i,
	input  wire logic                        reread_request_n_i,
	// Outputs
	output logic      [dcf_pkg::DATA_W-1:0]  read_data_o,
	output logic                             empty_indicator_n_o,
	output logic                             out_valid_o,
	output logic                             full_flag_n_o,
	output logic                             near_empty_flag_n_o,
	output logic                             near_full_flag_n_o
);
	dcf_pkg::dcf_opt_t   opt;
	dcf_pkg::dcf_state_t st;
	dcf_pkg::dcf_state_t next_st;

	logic [dcf_pkg::DATA_W-1:0] mem [dcf_pkg::DEPTH];
	logic                       mem_we;
	logic [dcf_pkg::ADDR_W-1:0] mem_addr;
	logic [dcf_pkg::DATA_W-1:0] mem_wdata;

	logic                       init_any;
	logic [dcf_pkg::ADDR_W:0]   cnt;
	logic [dcf_pkg::ADDR_W:0]   ncnt;
	logic [dcf_pkg::ADDR_W:0]   rd_ptr_v;
	logic [1:0]                 rd_part_v;
	logic [1:0]                 wslot;
	logic [dcf_pkg::DATA_W-1:0] word;
	logic [dcf_pkg::OFF_W-1:0]  off_val;
	logic [2*dcf_pkg::OFF_W-1:0] off_shift;
	logic [dcf_pkg::OFF_W-1:0]  cnt_ext;
	logic [dcf_pkg::OFF_W-1:0]  free_ext;
	logic                       load;
	logic                       wr_go;
	logic                       rd_event;

	dcf_opt_latch u_opt (
		.core_clk_i                     (core_clk_i),
		.reset_n_i                      (reset_n_i),
		.full_init_n_i                  (full_init_n_i),
		.first_word_show_or_serial_in_i (first_word_show_or_serial_in_i),
		.offset_access_n_i              (offset_access_n_i),
		.width_match_en_i               (width_match_en_i),
		.write_width_sel_i              (write_width_sel_i),
		.read_width_sel_i               (read_width_sel_i),
		.byte_order_sel_n_i             (byte_order_sel_n_i),
		.reread_latency_sel_i           (reread_latency_sel_i),
		.threshold_flag_timing_sel_i    (threshold_flag_timing_sel_i),
		.parity_position_sel_i          (parity_position_sel_i),
		.opt_o                          (opt)
	);

	assign init_any = !full_init_n_i || !pointer_only_init_n_i;

	always_comb begin
		next_st   = st;
		mem_we    = 1'b0;
		mem_addr  = st.wr_ptr[dcf_pkg::ADDR_W-1:0];
		mem_wdata = '0;
		cnt       = st.wr_ptr - st.rd_ptr;
		ncnt      = cnt;
		rd_ptr_v  = st.rd_ptr;
		rd_part_v = st.rd_part;
		wslot     = dcf_pkg::dcf_slot(st.wr_part, opt.wr_w, opt.big_endian);
		word      = dcf_pkg::dcf_put_slot(st.wr_buf, opt.wr_w, wslot,
			write_data_i);
		off_val   = opt.interspersed ?
			{write_data_i[dcf_pkg::IGN_BIT:dcf_pkg::PAR_BIT+1],
			write_data_i[dcf_pkg::PAR_BIT-1:0]} :
			write_data_i[dcf_pkg::IGN_BIT-1:0];
		off_shift = {st.off_full[dcf_pkg::OFF_W-2:0], st.off_empty,
			first_word_show_or_serial_in_i};
		cnt_ext   = '0;
		free_ext  = '0;
		load      = 1'b0;
		wr_go     = 1'b0;
		rd_event  = !read_en_n_i || !reread_request_n_i;
		if (init_any) begin
			// Both inits clear the data path the same way
			next_st = dcf_pkg::STATE_RST;
			next_st.off_empty = st.off_empty;
			next_st.off_full  = st.off_full;
			if (!full_init_n_i) begin
				next_st.off_empty = dcf_pkg::dcf_preset({offset_access_n_i,
					default_limit_pick1_i, default_limit_pick0_i});
				next_st.off_full  = next_st.off_empty;
			end
		end else begin
			if (!offset_access_n_i) begin
				// Offset loading steals the write strobe from the FIFO
				if (!write_en_n_i && !opt.serial_method) begin
					if (st.off_hi)
						next_st.off_full = off_val;
					else
						next_st.off_empty = off_val;
					next_st.off_hi = !st.off_hi;
				end else if (!serial_load_n_i && opt.serial_method) begin
					next_st.off_full  = off_shift[2*dcf_pkg::OFF_W-1:
						dcf_pkg::OFF_W];
					next_st.off_empty = off_shift[dcf_pkg::OFF_W-1:0];
				end
			end else if (!write_en_n_i && cnt != dcf_pkg::FULL_CNT) begin
				wr_go = 1'b1;
				if (st.wr_part == dcf_pkg::dcf_last_part(opt.wr_w)) begin
					mem_we          = 1'b1;
					mem_wdata       = word;
					next_st.wr_ptr  = st.wr_ptr + dcf_pkg::PTR_ONE;
					next_st.wr_part = '0;
					next_st.wr_buf  = '0;
				end else begin
					next_st.wr_buf  = word;
					next_st.wr_part = st.wr_part + dcf_pkg::PART_ONE;
				end
			end
			if (!reread_request_n_i) begin
				rd_ptr_v  = '0;
				rd_part_v = '0;
				// Zero latency or show mode fetch location zero now
				load = opt.first_word_show_mode || opt.zero_lat;
			end else if (opt.first_word_show_mode) begin
				load = cnt != '0 && (!st.out_valid || !read_en_n_i);
				if (st.out_valid && !read_en_n_i && cnt == '0)
					next_st.out_valid = 1'b0;
			end else begin
				load = !read_en_n_i && cnt != '0;
			end
			if (load) begin
				next_st.dout = dcf_pkg::dcf_get_slot(
					mem[rd_ptr_v[dcf_pkg::ADDR_W-1:0]], opt.rd_w,
					dcf_pkg::dcf_slot(rd_part_v, opt.rd_w, opt.big_endian));
				next_st.out_valid = 1'b1;
				if (rd_part_v == dcf_pkg::dcf_last_part(opt.rd_w)) begin
					rd_ptr_v  = rd_ptr_v + dcf_pkg::PTR_ONE;
					rd_part_v = '0;
				end else begin
					rd_part_v = rd_part_v + dcf_pkg::PART_ONE;
				end
			end
			next_st.rd_ptr  = rd_ptr_v;
			next_st.rd_part = rd_part_v;
			ncnt     = next_st.wr_ptr - next_st.rd_ptr;
			cnt_ext  = {{(dcf_pkg::OFF_W-dcf_pkg::ADDR_W-1){1'b0}}, ncnt};
			free_ext = {{(dcf_pkg::OFF_W-dcf_pkg::ADDR_W-1){1'b0}},
				dcf_pkg::FULL_CNT - ncnt};
			next_st.empty_n = reread_request_n_i && ncnt != '0;
			next_st.full_n  = ncnt != dcf_pkg::FULL_CNT;
			if (!opt.sync_flags || rd_event)
				next_st.near_empty_n = !(cnt_ext < next_st.off_empty);
			if (!opt.sync_flags || wr_go)
				next_st.near_full_n = free_ext > next_st.off_full;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			st <= dcf_pkg::STATE_RST;
		else
			st <= next_st;
	end

	// Storage has no reset; contents are undefined until written
	always_ff @(posedge core_clk_i) begin
		if (mem_we)
			mem[mem_addr] <= mem_wdata;
	end

	assign read_data_o         = st.dout;
	assign empty_indicator_n_o = st.empty_n;
	assign out_valid_o         = st.out_valid;
	assign full_flag_n_o       = st.full_n;
	assign near_empty_flag_n_o = st.near_empty_n;
	assign near_full_flag_n_o  = st.near_full_n;

	default clocking dcf_cb @(posedge core_clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_full_init_clear: assert property (!full_init_n_i |=>
		st.wr_ptr == '0 && st.rd_ptr == '0 && read_data_o == '0)
		else $error("full init left pointers or output");
	a_partial_clear: assert property (!pointer_only_init_n_i |=>
		st.wr_ptr == '0 && st.rd_ptr == '0 && read_data_o == '0)
		else $error("pointer init left pointers or output");
	a_partial_keep: assert property (full_init_n_i &&
		!pointer_only_init_n_i |=> $stable(st.off_empty) &&
		$stable(st.off_full) && $stable(opt))
		else $error("pointer init disturbed settings");
	a_reread_pointer: assert property (!init_any && !reread_request_n_i &&
		!opt.first_word_show_mode && !opt.zero_lat && write_en_n_i |=>
		st.rd_ptr == '0 && $stable(st.wr_ptr) && $stable(st.off_empty))
		else $error("reread pointer wrong");
	a_reread_flag: assert property (!init_any && !reread_request_n_i |=>
		(opt.first_word_show_mode ? out_valid_o : !empty_indicator_n_o))
		else $error("reread indicator wrong");
	a_zero_latency: assert property (!init_any && !reread_request_n_i &&
		opt.zero_lat && opt.rd_w == dcf_pkg::DCF_W72 |=>
		read_data_o == $past(mem[0]))
		else $error("zero latency word missing");
	a_sync_near_empty: assert property (!init_any && opt.sync_flags &&
		read_en_n_i && reread_request_n_i |=> $stable(near_empty_flag_n_o))
		else $error("near empty moved without read");
	a_write_store: assert property (!init_any && offset_access_n_i &&
		!write_en_n_i && opt.wr_w == dcf_pkg::DCF_W72 && full_flag_n_o |=>
		st.wr_ptr == $past(st.wr_ptr) + dcf_pkg::PTR_ONE)
		else $error("write not stored");
	a_parity_load: assert property (!init_any && !offset_access_n_i &&
		!write_en_n_i && !opt.serial_method && !st.off_hi &&
		opt.interspersed |=> st.off_empty ==
		{$past(write_data_i[dcf_pkg::IGN_BIT:dcf_pkg::PAR_BIT+1]),
		$past(write_data_i[dcf_pkg::PAR_BIT-1:0])})
		else $error("parity bit not skipped");
endmodule

// [dcf_far_end.sv]
`timescale 1ns/100ps
module dcf_far_end (
	// Commands from the bench
	input  wire logic                       send_i,
	input  wire dcf_pkg::dcf_width_t        width_i,
	input  wire logic [dcf_pkg::DATA_W-1:0] word_i,
	// Write port of the block
	output logic                            write_en_n_o,
	output logic      [dcf_pkg::DATA_W-1:0] write_data_o
);
	logic [dcf_pkg::DATA_W-1:0] mask;

	always_comb begin
		case (width_i)
			dcf_pkg::DCF_W36: mask = 72'h000000000FFFFFFFFF;
			dcf_pkg::DCF_W18: mask = 72'h00000000000003FFFF;
			default: mask = '1;
		endcase
	end

	// Idle data is inverted so a stale word is never mistaken for a new one
	assign write_en_n_o = ~send_i;
	assign write_data_o = (send_i ? word_i : ~word_i) & mask;
endmodule

// [dcf_opt_latch.sv]
`timescale 1ns/100ps
module dcf_opt_latch (
	// Clock and reset
	input  wire logic          core_clk_i,
	input  wire logic          reset_n_i,
	// Capture window
	input  wire logic          full_init_n_i,
	// Straps
	input  wire logic          first_word_show_or_serial_in_i,
	input  wire logic          offset_access_n_i,
	input  wire logic          width_match_en_i,
	input  wire logic          write_width_sel_i,
	input  wire logic          read_width_sel_i,
	input  wire logic          byte_order_sel_n_i,
	input  wire logic          reread_latency_sel_i,
	input  wire logic          threshold_flag_timing_sel_i,
	input  wire logic          parity_position_sel_i,
	// Captured options
	output dcf_pkg::dcf_opt_t  opt_o
);
	dcf_pkg::dcf_opt_t   opt;
	dcf_pkg::dcf_opt_t   next_opt;
	dcf_pkg::dcf_ports_t ports;

	always_comb begin
		next_opt = opt;
		ports = dcf_pkg::dcf_port_widths(width_match_en_i,
			write_width_sel_i, read_width_sel_i);
		if (!full_init_n_i) begin
			next_opt.first_word_show_mode          = first_word_show_or_serial_in_i;
			next_opt.serial_method = offset_access_n_i;
			next_opt.wr_w          = ports.wr_w;
			next_opt.rd_w          = ports.rd_w;
			next_opt.big_endian    = !byte_order_sel_n_i;
			next_opt.zero_lat      = !reread_latency_sel_i;
			next_opt.sync_flags    = threshold_flag_timing_sel_i;
			next_opt.interspersed  = parity_position_sel_i;
		end
	end

	always_ff @(posedge core_clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			opt <= dcf_pkg::OPT_RST;
		else
			opt <= next_opt;
	end

	assign opt_o = opt;

	a_opt_hold: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
		full_init_n_i |=> $stable(opt_o))
		else $error("options moved outside full init");
	a_order_capture: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		!full_init_n_i |=> opt_o.big_endian != $past(byte_order_sel_n_i))
		else $error("byte order not captured");
	a_latency_capture: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		!full_init_n_i |=> opt_o.zero_lat != $past(reread_latency_sel_i))
		else $error("reread latency not captured");
	a_flag_capture: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		!full_init_n_i ##1 full_init_n_i |->
		opt_o.sync_flags == $past(threshold_flag_timing_sel_i))
		else $error("flag timing not captured");
	a_parity_capture: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		!full_init_n_i |=> opt_o.interspersed == $past(parity_position_sel_i))
		else $error("parity position not captured");
	a_mode_capture: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		!full_init_n_i |=>
		opt_o.first_word_show_mode == $past(first_word_show_or_serial_in_i))
		else $error("read timing mode not captured");
	a_width_capture: assert property (@(posedge core_clk_i)
		disable iff (!reset_n_i)
		!full_init_n_i && !width_match_en_i |=>
		opt_o.wr_w == dcf_pkg::DCF_W72 && opt_o.rd_w == dcf_pkg::DCF_W72)
		else $error("unmatched widths not 72");
endmodule

// [dcf_pkg.sv]
// Function
// - Full init clears both pointers and the output register.
// - Full init captures every static option from the strap inputs.
// - Pointer-only init clears both pointers and the output register.
// - Pointer-only init keeps timing mode, load method and flag offsets.
// - Reread request resets the read pointer; write pointer and offsets are kept.
// - Reread drives empty indicator low, or output valid high in show mode.
// - Shared pin picks read timing in full init, later is serial input.
// - Both port widths come from match, write and read width selects.
// - Byte order strap low means big-endian, high means little-endian.
// - Reread latency strap low means zero latency, high means normal.
// - Flag timing strap low means asynchronous, high means synchronous.
// - Parity strap low means non-interspersed, high means interspersed.
// - Two picks plus offset access choose one of eight preset offsets.
// - Enabled write stores data in the FIFO, or in offsets when loading.
// - Width table: 72/72, narrow write to 72 read, 72 write to narrow read.
// - Interspersed parity skips bit 8; otherwise bits 16 and 17 ignored.
// - Zero-latency reread shows the first word on the requesting edge.
// - Synchronous flags: near-empty moves on reads, near-full on writes.
package dcf_pkg;
	localparam int DATA_W  = 72;
	localparam int DEPTH   = 16;
	localparam int ADDR_W  = 4;
	localparam int OFF_W   = 16;
	localparam int SUB36_W = 36;
	localparam int SUB18_W = 18;
	localparam int PAR_BIT = 8;
	localparam int IGN_BIT = 16;
	localparam logic [ADDR_W:0] FULL_CNT = 5'h10;
	localparam logic [ADDR_W:0] PTR_ONE  = 5'h01;
	localparam logic [1:0]      PART_ONE = 2'h1;

	typedef enum logic [1:0] {DCF_W72, DCF_W36, DCF_W18} dcf_width_t;

	typedef struct packed {
		dcf_width_t wr_w;
		dcf_width_t rd_w;
	} dcf_ports_t;

	typedef struct packed {
		logic       first_word_show_mode;
		logic       serial_method;
		dcf_width_t wr_w;
		dcf_width_t rd_w;
		logic       big_endian;
		logic       zero_lat;
		logic       sync_flags;
		logic       interspersed;
	} dcf_opt_t;

	localparam dcf_opt_t OPT_RST = '0;

	typedef struct packed {
		logic [ADDR_W:0]   wr_ptr;
		logic [ADDR_W:0]   rd_ptr;
		logic [1:0]        wr_part;
		logic [1:0]        rd_part;
		logic [DATA_W-1:0] wr_buf;
		logic [DATA_W-1:0] dout;
		logic              out_valid;
		logic              empty_n;
		logic              full_n;
		logic              near_empty_n;
		logic              near_full_n;
		logic [OFF_W-1:0]  off_empty;
		logic [OFF_W-1:0]  off_full;
		logic              off_hi;
	} dcf_state_t;

	localparam dcf_state_t STATE_RST = '{full_n: 1'b1, near_full_n: 1'b1,
		default: '0};

	function automatic dcf_ports_t dcf_port_widths(logic match, logic wsel,
		logic rsel);
		dcf_ports_t p;
		p.wr_w = DCF_W72;
		p.rd_w = DCF_W72;
		if (match) begin
			if (wsel)
				p.wr_w = rsel ? DCF_W18 : DCF_W36;
			else
				p.rd_w = rsel ? DCF_W18 : DCF_W36;
		end
		return p;
	endfunction

	function automatic logic [1:0] dcf_last_part(dcf_width_t w);
		case (w)
			DCF_W36: return 2'h1;
			DCF_W18: return 2'h3;
			default: return 2'h0;
		endcase
	endfunction

	// Big-endian puts the first sub-word in the top slot
	function automatic logic [1:0] dcf_slot(logic [1:0] part, dcf_width_t w,
		logic big);
		logic [1:0] r;
		r = big ? dcf_last_part(w) - part : part;
		return r;
	endfunction

	function automatic logic [DATA_W-1:0] dcf_get_slot(
		logic [DATA_W-1:0] word, dcf_width_t w, logic [1:0] slot);
		logic [DATA_W-1:0] r;
		r = '0;
		case (w)
			DCF_W36: r[SUB36_W-1:0] = word[slot[0]*SUB36_W +: SUB36_W];
			DCF_W18: r[SUB18_W-1:0] = word[slot*SUB18_W +: SUB18_W];
			default: r = word;
		endcase
		return r;
	endfunction

	function automatic logic [DATA_W-1:0] dcf_put_slot(
		logic [DATA_W-1:0] word, dcf_width_t w, logic [1:0] slot,
		logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] r;
		r = word;
		case (w)
			DCF_W36: r[slot[0]*SUB36_W +: SUB36_W] = d[SUB36_W-1:0];
			DCF_W18: r[slot*SUB18_W +: SUB18_W] = d[SUB18_W-1:0];
			default: r = d;
		endcase
		return r;
	endfunction

	function automatic logic [OFF_W-1:0] dcf_preset(logic [2:0] idx);
		case (idx)
			3'h0: return 16'h0007;
			3'h1: return 16'h0001;
			3'h2: return 16'h0003;
			3'h3: return 16'h0005;
			3'h4: return 16'h0002;
			3'h5: return 16'h0004;
			3'h6: return 16'h0006;
			default: return 16'h0008;
		endcase
	endfunction
endpackage

// [dual_clock_fifo_reset_config_tb_top.sv]
`timescale 1ns/100ps
module dual_clock_fifo_reset_config_tb_top;
	logic                       clk     = 1'b0;
	logic                       rst_n   = 1'b0;
	logic                       fi_n    = 1'b1;
	logic                       poi_n   = 1'b1;
	logic                       show    = 1'b0;
	logic                       match   = 1'b0;
	logic                       wsel    = 1'b0;
	logic                       rsel    = 1'b0;
	logic                       order_n = 1'b1;
	logic                       lat_sel = 1'b1;
	logic                       sync_sel = 1'b0;
	logic                       par_sel = 1'b0;
	logic                       acc_n   = 1'b1;
	logic                       pick1   = 1'b0;
	logic                       pick0   = 1'b0;
	logic                       sload_n = 1'b1;
	logic                       rd_n    = 1'b1;
	logic                       rr_n    = 1'b1;
	logic                       send    = 1'b0;
	dcf_pkg::dcf_width_t        width   = dcf_pkg::DCF_W72;
	logic [dcf_pkg::DATA_W-1:0] word    = '0;
	logic                       wr_n;
	logic [dcf_pkg::DATA_W-1:0] wdata;
	logic [dcf_pkg::DATA_W-1:0] q;
	logic                       empty_n;
	logic                       ovalid;
	logic                       full_n;
	logic                       ne_n;
	logic                       nf_n;
	int                         n_errors = 0;
	int                         n_tests  = 0;
	logic [3:0]                 pre [8] = '{4'h7, 4'h1, 4'h3, 4'h5,
		4'h2, 4'h4, 4'h6, 4'h8};

	always #2 clk = ~clk;

	dcf_far_end dcf_far_end_i (
		.send_i       (send),
		.width_i      (width),
		.word_i       (word),
		.write_en_n_o (wr_n),
		.write_data_o (wdata)
	);

	dcf_ctrl dcf_ctrl_i (
		.core_clk_i                     (clk),
		.reset_n_i                      (rst_n),
		.full_init_n_i                  (fi_n),
		.pointer_only_init_n_i          (poi_n),
		.first_word_show_or_serial_in_i (show),
		.width_match_en_i               (match),
		.write_width_sel_i              (wsel),
		.read_width_sel_i               (rsel),
		.byte_order_sel_n_i             (order_n),
		.reread_latency_sel_i           (lat_sel),
		.threshold_flag_timing_sel_i    (sync_sel),
		.parity_position_sel_i          (par_sel),
		.default_limit_pick0_i          (pick0),
		.default_limit_pick1_i          (pick1),
		.offset_access_n_i              (acc_n),
		.write_en_n_i                   (wr_n),
		.write_data_i                   (wdata),
		.serial_load_n_i                (sload_n),
		.read_en_n_i                    (rd_n),
		.reread_request_n_i             (rr_n),
		.read_data_o                    (q),
		.empty_indicator_n_o            (empty_n),
		.out_valid_o                    (ovalid),
		.full_flag_n_o                  (full_n),
		.near_empty_flag_n_o            (ne_n),
		.near_full_flag_n_o             (nf_n)
	);

	task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run;
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Straps other than offset access flip after init so a design that keeps sampling them is caught
	task automatic full_init(input logic [10:0] s);
		@(posedge clk);
		{show, match, wsel, rsel, order_n, lat_sel, sync_sel, par_sel,
			acc_n, pick1, pick0} <= s;
		fi_n <= 1'b0;
		repeat (2) @(posedge clk);
		fi_n <= 1'b1;
		{show, match, wsel, rsel, order_n, lat_sel, sync_sel, par_sel,
			acc_n, pick1, pick0} <= {~s[10:3], 1'b1, ~s[1:0]};
		#1;
	endtask

	task automatic put(input logic [71:0] w, input dcf_pkg::dcf_width_t wd);
		@(posedge clk);
		send  <= 1'b1;
		word  <= w;
		width <= wd;
		@(posedge clk);
		send <= 1'b0;
	endtask

	task automatic rd;
		@(posedge clk);
		rd_n <= 1'b0;
		@(posedge clk);
		rd_n <= 1'b1;
		#1;
	endtask

	task automatic reread;
		@(posedge clk);
		rr_n <= 1'b0;
		@(posedge clk);
		rr_n <= 1'b1;
		#1;
	endtask

	task automatic settle;
		repeat (2) @(posedge clk);
		#1;
	endtask

	task automatic t_basic;
		full_init({8'h0C, 3'h1});
		chk(q, '0);
		chk(empty_n, 1'b0);
		chk(full_n, 1'b1);
		put(72'hA1A2A3A4A5A6A7A8A9, dcf_pkg::DCF_W72);
		put(72'hB1B2B3B4B5B6B7B8B9, dcf_pkg::DCF_W72);
		rd;
		chk(q, 72'hA1A2A3A4A5A6A7A8A9);
		rd;
		chk(q, 72'hB1B2B3B4B5B6B7B8B9);
		reread;
		chk(empty_n, 1'b0);
		chk(q, 72'hB1B2B3B4B5B6B7B8B9);
		rd;
		chk(q, 72'hA1A2A3A4A5A6A7A8A9);
		settle;
		chk(empty_n, 1'b1);
		@(posedge clk);
		poi_n <= 1'b0;
		@(posedge clk);
		poi_n <= 1'b1;
		settle;
		chk(q, '0);
		chk(empty_n, 1'b0);
		chk(ne_n, 1'b0);
		put(72'hC1, dcf_pkg::DCF_W72);
		settle;
		chk(ne_n, 1'b1);
	endtask

	task automatic t_presets;
		for (int i = 0; i < 8; i++) begin
			full_init({8'h0C, i[2:0]});
			for (int k = 1; k < pre[i]; k++)
				put(72'h5, dcf_pkg::DCF_W72);
			settle;
			chk(ne_n, 1'b0);
			put(72'h6, dcf_pkg::DCF_W72);
			settle;
			chk(ne_n, 1'b1);
		end
	endtask

	task automatic t_first_word_show_mode;
		full_init({8'hF0, 3'h4});
		put(72'h11111, dcf_pkg::DCF_W18);
		put(72'h22222, dcf_pkg::DCF_W18);
		put(72'h33333, dcf_pkg::DCF_W18);
		put(72'h04444, dcf_pkg::DCF_W18);
		repeat (3) settle;
		chk(ovalid, 1'b1);
		chk(q, {18'h11111, 18'h22222, 18'h33333, 18'h04444});
		rd;
		settle;
		chk(ovalid, 1'b0);
		reread;
		chk(ovalid, 1'b1);
		chk(q, {18'h11111, 18'h22222, 18'h33333, 18'h04444});
	endtask

	task automatic t_narrow;
		full_init({8'h4C, 3'h4});
		put(72'h123456789ABCDEF012, dcf_pkg::DCF_W72);
		rd;
		chk(q, 72'h000000000ABCDEF012);
		rd;
		chk(q, 72'h000000000123456789);
		full_init({8'h64, 3'h4});
		put(72'h123456789, dcf_pkg::DCF_W36);
		put(72'hABCDEF012, dcf_pkg::DCF_W36);
		rd;
		chk(q, 72'h123456789ABCDEF012);
		full_init({8'h5C, 3'h4});
		put({18'h00004, 18'h00003, 18'h00002, 18'h00001},
			dcf_pkg::DCF_W72);
		for (int j = 1; j < 5; j++) begin
			rd;
			chk(q, 72'(j));
		end
	endtask

	// Fill to the brim, then one extra write that must be dropped
	task automatic t_full;
		full_init({8'h0C, 3'h1});
		repeat (14) put(72'h9, dcf_pkg::DCF_W72);
		settle;
		chk(nf_n, 1'b1);
		put(72'hA, dcf_pkg::DCF_W72);
		settle;
		chk(nf_n, 1'b0);
		chk(full_n, 1'b1);
		put(72'hB, dcf_pkg::DCF_W72);
		put(72'hC, dcf_pkg::DCF_W72);
		settle;
		chk(full_n, 1'b0);
		repeat (16) rd;
		chk(q, 72'hB);
		chk(empty_n, 1'b0);
	endtask

	// Serial method: 32 shifts leave empty offset 3, full offset 0
	task automatic t_serial;
		full_init({8'h0C, 3'h4});
		for (int i = 0; i < 32; i++) begin
			@(posedge clk);
			acc_n   <= 1'b0;
			sload_n <= 1'b0;
			show    <= i >= 30;
		end
		@(posedge clk);
		acc_n   <= 1'b1;
		sload_n <= 1'b1;
		put(72'h1, dcf_pkg::DCF_W72);
		put(72'h2, dcf_pkg::DCF_W72);
		settle;
		chk(ne_n, 1'b0);
		put(72'h3, dcf_pkg::DCF_W72);
		settle;
		chk(ne_n, 1'b1);
	endtask

	task automatic t_sync;
		full_init({8'h0E, 3'h1});
		put(72'h7, dcf_pkg::DCF_W72);
		put(72'h8, dcf_pkg::DCF_W72);
		settle;
		chk(ne_n, 1'b0);
		rd;
		settle;
		chk(ne_n, 1'b1);
	endtask

	// Bit 8 is a parity slot in one mode and a value bit in the other
	task automatic t_parity;
		for (int p = 0; p < 2; p++) begin
			full_init({7'h06, p[0], 3'h1});
			@(posedge clk);
			acc_n <= 1'b0;
			put(p ? 72'h103 : 72'h10003, dcf_pkg::DCF_W72);
			put(72'h0, dcf_pkg::DCF_W72);
			@(posedge clk);
			acc_n <= 1'b1;
			put(72'h1, dcf_pkg::DCF_W72);
			put(72'h2, dcf_pkg::DCF_W72);
			settle;
			chk(ne_n, 1'b0);
			put(72'h3, dcf_pkg::DCF_W72);
			settle;
			chk(ne_n, 1'b1);
		end
	endtask

	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		t_basic;
		t_presets;
		t_first_word_show_mode;
		t_narrow;
		t_sync;
		t_parity;
		t_full;
		t_serial;
		complete_run;
	end

	// Whole run needs well under a thousand cycles
	initial begin
		#40000;
		n_errors++;
		complete_run;
	end
endmodule
